// ---- bph_consts.vh ----
// constants for the byte ports with handshake block
`ifndef BPH_CONSTS_VH
`define BPH_CONSTS_VH
`define BPH_ADDR_BYTE_PORT 8'h01
`define BPH_ADDR_BIT_PORT 8'h02
`define BPH_ADDR_CTRL_PORT 8'h03
`define BPH_ADDR_BIT_DIR 8'hf6
`define BPH_ADDR_CTRL_MODE 8'hf7
`define BPH_ADDR_SHARED_MODE 8'hf8
`define BPH_BYTE_DIR_HI 4
`define BPH_BYTE_DIR_LO 3
`define BPH_BYTE_MODE_OUT 2'b00
`define BPH_BYTE_MODE_IN 2'b01
`define BPH_CM_PUSH_PULL 0
`define BPH_CM_BYTE_HS_HI 4
`define BPH_CM_BYTE_HS_LO 3
`define BPH_CM_BIT_HS 6
`define BPH_CTRL_BIT_STROBE 1
`define BPH_CTRL_BYTE_STROBE 3
`define BPH_CTRL_BYTE_HS_OUT 0
`define BPH_CTRL_BIT_HS_OUT 2
`define BPH_BIT_LINE_SDI 0
`define BPH_BIT_LINE_SDO 7
`define BPH_BIT_HS_REF 7
`define BPH_RST_SHARED_MODE 8'h08
`define BPH_RST_CTRL_MODE 8'h00
`define BPH_RST_BIT_DIR 8'hff
`define BPH_RST_BYTE 8'h00
`define BPH_RST_CTRL_OUT 4'hf
`define BPH_FIFO_DEPTH 16
`define BPH_FIFO_AW 4
`endif

// ---- bph_fifo.v ----
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bph_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    assign in_ready_o = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    always @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bph_periph_model.sv ----
// peripheral model on the byte port handshake lines
`timescale 1ns/1ps
`default_nettype none
module bph_periph_model (
    input wire logic clk_i,
    input wire logic [7:0] dev_data_i,
    input wire logic dev_hs_i,
    output logic [7:0] peer_data_o,
    output logic peer_hs_o
);
    logic rx_en;
    int rx_count;
    logic [7:0] rx_last;
    initial begin
        peer_data_o = 8'h00;
        peer_hs_o = 1'b1;
        rx_en = 1'b0;
        rx_count = 0;
        rx_last = 8'h00;
    end
    // data on the lines without a strobe
    task automatic drive(input logic [7:0] d);
        @(posedge clk_i);
        peer_data_o <= d;
    endtask
    // data, falling strobe, wait for ready low, then release
    task automatic send(input logic [7:0] d, input logic wait_ready);
        int k;
        @(posedge clk_i);
        peer_data_o <= d;
        @(posedge clk_i);
        peer_hs_o <= 1'b0;
        for (k = 0; k < 50 && wait_ready && dev_hs_i !== 1'b0; k++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        peer_hs_o <= 1'b1;
        @(posedge clk_i);
        peer_data_o <= ~d;
    endtask
    // receiver: latch on data-valid low, ready low until data-valid high
    always @(posedge clk_i) begin
        if (rx_en && peer_hs_o && dev_hs_i === 1'b0) begin
            rx_last <= dev_data_i;
            rx_count <= rx_count + 1;
            peer_hs_o <= 1'b0;
        end else if (rx_en && !peer_hs_o && dev_hs_i === 1'b1) begin
            peer_hs_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- bph_ports.v ----
// byte port, bit port and control port with interlocked handshake
// Summary of operation
// - byte port data register lives at 01h; writes load its output register
// - byte port read in output mode returns pin levels
// - byte port read in input mode without handshake returns pin levels
// - handshake inputs read the strobe-captured input register, not live pins
// - byte direction from shared mode bits 4:3; 00 output, 01 input
// - byte port may instead carry multiplexed external address/data
// - byte port handshake on only when control mode bits 4 and 3 set
// - byte handshake: line3 strobe/ready in, line4 ready/strobe out
// - byte handshake direction follows byte port direction
// - bit port direction per bit from register f6h; one is input
// - bit port write at 02h drives output lines at once
// - bit port output line read returns external pin level
// - one global setting picks push-pull or open-drain for bit port outputs
// - with serial enabled, bit line0 is serial in, line7 serial out
// - bit port handshake enabled by control mode bit 6
// - bit handshake: line1 strobe/ready in, line6 ready/strobe out
// - bit handshake follows bit7 direction; only matching lines take part
// - control port lines 0-3 always inputs, 4-7 always outputs
// - control port has one shared input and one shared output register
// - control writes at 03h skip output lines used by handshake
// - control read gives input levels and driven output line levels
// - first falling strobe captures data; held until software reads
// - ready returns high only after read and with strobe high
// - output write drops data-valid low only while ready input high
// - falling ready input in output handshake raises an interrupt request
`timescale 1ns/1ps
`default_nettype none
`include "bph_consts.vh"
module bph_ports (
    input wire CORE_CLK_I,
    input wire RST_B_I,
    input wire [7:0] REG_ADDR_I,
    input wire REG_WR_I,
    input wire [7:0] REG_WDATA_I,
    input wire REG_RD_I,
    output reg [7:0] REG_RDATA_O,
    input wire [7:0] BYTE_PORT_I,
    output reg [7:0] BYTE_PORT_O,
    output reg [7:0] BYTE_PORT_OE_O,
    input wire [7:0] EXT_MEM_AD_I,
    input wire EXT_MEM_AD_OE_I,
    output reg BYTE_TX_READY_O,
    input wire [7:0] BIT_PORT_I,
    output reg [7:0] BIT_PORT_O,
    output reg [7:0] BIT_PORT_OE_O,
    input wire SERIAL_EN_I,
    input wire SERIAL_DATA_OUT_I,
    output reg SERIAL_DATA_IN_O,
    input wire [3:0] CTRL_PORT_I,
    output reg [3:0] CTRL_PORT_O,
    output reg BYTE_HS_IRQ_O,
    output reg BIT_HS_IRQ_O
);
    localparam ST_IDLE = 2'b01;
    localparam ST_SENT = 2'b10;
    reg [7:0] shared_port_mode_reg;
    reg [7:0] control_port_mode_reg;
    reg [7:0] bit_port_direction_reg;
    reg [7:0] byte_out_reg;
    reg [7:0] byte_in_reg;
    reg [7:0] bit_out_reg;
    reg [7:0] bit_in_reg;
    reg [3:0] ctrl_out_reg;
    reg [3:0] ctrl_sync1_reg;
    reg [3:0] ctrl_sync2_reg;
    reg [3:0] ctrl_prev_reg;
    reg byte_latched_reg;
    reg bit_latched_reg;
    reg byte_rdy_reg;
    reg bit_rdy_reg;
    reg [1:0] byte_tx_state_reg;
    reg [1:0] byte_tx_state_next;
    reg bit_dav_reg;
    reg [7:0] rdata_next;
    reg [3:0] ctrl_pins_next;
    wire [1:0] byte_mode;
    wire byte_is_out;
    wire byte_is_in;
    wire byte_is_ad;
    wire byte_hs_en;
    wire byte_in_hs;
    wire byte_out_hs;
    wire bit_hs_en;
    wire bit_in_hs;
    wire bit_out_hs;
    wire [7:0] bit_hs_lines;
    wire byte_strobe;
    wire bit_strobe;
    wire byte_strobe_fall;
    wire bit_strobe_fall;
    wire wr_byte;
    wire wr_bit;
    wire rd_byte;
    wire rd_bit;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [7:0] fifo_out_data;
    wire [7:0] bit_read;
    assign byte_mode = {shared_port_mode_reg[`BPH_BYTE_DIR_HI], shared_port_mode_reg[`BPH_BYTE_DIR_LO]};
    assign byte_is_out = (byte_mode == `BPH_BYTE_MODE_OUT);
    assign byte_is_in = (byte_mode == `BPH_BYTE_MODE_IN);
    assign byte_is_ad = shared_port_mode_reg[`BPH_BYTE_DIR_HI];
    assign byte_hs_en = control_port_mode_reg[`BPH_CM_BYTE_HS_HI] & control_port_mode_reg[`BPH_CM_BYTE_HS_LO];
    assign byte_in_hs = byte_hs_en & byte_is_in;
    assign byte_out_hs = byte_hs_en & byte_is_out;
    assign bit_hs_en = control_port_mode_reg[`BPH_CM_BIT_HS];
    assign bit_in_hs = bit_hs_en & bit_port_direction_reg[`BPH_BIT_HS_REF];
    assign bit_out_hs = bit_hs_en & ~bit_port_direction_reg[`BPH_BIT_HS_REF];
    assign bit_hs_lines = bit_port_direction_reg ~^ {8{bit_port_direction_reg[`BPH_BIT_HS_REF]}};
    // edges seen only after the two-flop stage
    assign byte_strobe = ctrl_sync2_reg[`BPH_CTRL_BYTE_STROBE];
    assign bit_strobe = ctrl_sync2_reg[`BPH_CTRL_BIT_STROBE];
    assign byte_strobe_fall = ctrl_prev_reg[`BPH_CTRL_BYTE_STROBE] & ~byte_strobe;
    assign bit_strobe_fall = ctrl_prev_reg[`BPH_CTRL_BIT_STROBE] & ~bit_strobe;
    assign wr_byte = REG_WR_I & (REG_ADDR_I == `BPH_ADDR_BYTE_PORT);
    assign wr_bit = REG_WR_I & (REG_ADDR_I == `BPH_ADDR_BIT_PORT);
    assign rd_byte = REG_RD_I & (REG_ADDR_I == `BPH_ADDR_BYTE_PORT);
    assign rd_bit = REG_RD_I & (REG_ADDR_I == `BPH_ADDR_BIT_PORT);
    // output handshake pops a queued byte only when idle and ready is high
    assign fifo_out_ready = byte_out_hs & (byte_tx_state_reg == ST_IDLE) & byte_strobe;
    bph_fifo #(
        .WIDTH(8),
        .DEPTH(`BPH_FIFO_DEPTH),
        .AW(`BPH_FIFO_AW)
    ) u_tx_fifo (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .in_valid_i(wr_byte & byte_out_hs),
        .in_ready_o(fifo_in_ready),
        .in_data_i(REG_WDATA_I),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );
    // mode and direction registers
    always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            shared_port_mode_reg <= `BPH_RST_SHARED_MODE;
            control_port_mode_reg <= `BPH_RST_CTRL_MODE;
            bit_port_direction_reg <= `BPH_RST_BIT_DIR;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == `BPH_ADDR_SHARED_MODE) begin
                shared_port_mode_reg <= REG_WDATA_I;
            end
            if (REG_ADDR_I == `BPH_ADDR_CTRL_MODE) begin
                control_port_mode_reg <= REG_WDATA_I;
            end
            if (REG_ADDR_I == `BPH_ADDR_BIT_DIR) begin
                bit_port_direction_reg <= REG_WDATA_I;
            end
        end
    end

    // synchronizer for incoming control lines
    always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            ctrl_sync1_reg <= 4'hf;
            ctrl_sync2_reg <= 4'hf;
            ctrl_prev_reg <= 4'hf;
        end else begin
            ctrl_sync1_reg <= CTRL_PORT_I;
            ctrl_sync2_reg <= ctrl_sync1_reg;
            ctrl_prev_reg <= ctrl_sync2_reg;
        end
    end

    // byte port input handshake
    always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            byte_in_reg <= `BPH_RST_BYTE;
            byte_latched_reg <= 1'b0;
            byte_rdy_reg <= 1'b1;
        end else if (!byte_in_hs) begin
            byte_latched_reg <= 1'b0;
            byte_rdy_reg <= 1'b1;
        end else if (byte_strobe_fall && !byte_latched_reg) begin
            byte_in_reg <= BYTE_PORT_I;
            byte_latched_reg <= 1'b1;
            byte_rdy_reg <= 1'b0;
        end else begin
            if (rd_byte) begin
                byte_latched_reg <= 1'b0;
            end
            if (!byte_latched_reg && byte_strobe) begin
                byte_rdy_reg <= 1'b1;
            end
        end
    end

    // byte port output handshake state
    always @* begin
        byte_tx_state_next = byte_tx_state_reg;
        case (byte_tx_state_reg)
            ST_IDLE: begin
                if (fifo_out_valid && fifo_out_ready) begin
                    byte_tx_state_next = ST_SENT;
                end
            end
            ST_SENT: begin
                if (!byte_strobe || !byte_out_hs) begin
                    byte_tx_state_next = ST_IDLE;
                end
            end
            default: begin
                byte_tx_state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            byte_tx_state_reg <= ST_IDLE;
            byte_out_reg <= `BPH_RST_BYTE;
        end else begin
            byte_tx_state_reg <= byte_tx_state_next;
            if (fifo_out_valid && fifo_out_ready) begin
                byte_out_reg <= fifo_out_data;
            end else if (wr_byte && !byte_out_hs) begin
                byte_out_reg <= REG_WDATA_I;
            end
        end
    end

    // bit port data and handshake
    always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            bit_out_reg <= `BPH_RST_BYTE;
            bit_in_reg <= `BPH_RST_BYTE;
            bit_latched_reg <= 1'b0;
            bit_rdy_reg <= 1'b1;
            bit_dav_reg <= 1'b1;
        end else begin
            if (wr_bit) begin
                bit_out_reg <= REG_WDATA_I;
            end
            if (!bit_in_hs) begin
                bit_latched_reg <= 1'b0;
                bit_rdy_reg <= 1'b1;
            end else if (bit_strobe_fall && !bit_latched_reg) begin
                bit_in_reg <= BIT_PORT_I;
                bit_latched_reg <= 1'b1;
                bit_rdy_reg <= 1'b0;
            end else begin
                if (rd_bit) begin
                    bit_latched_reg <= 1'b0;
                end
                if (!bit_latched_reg && bit_strobe) begin
                    bit_rdy_reg <= 1'b1;
                end
            end
            if (!bit_out_hs || !bit_strobe) begin
                bit_dav_reg <= 1'b1;
            end else if (wr_bit) begin
                bit_dav_reg <= 1'b0;
            end
        end
    end

    // interrupt requests: capture in input mode, falling ready in output mode
    always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            BYTE_HS_IRQ_O <= 1'b0;
            BIT_HS_IRQ_O <= 1'b0;
        end else begin
            BYTE_HS_IRQ_O <= (byte_in_hs & byte_strobe_fall & ~byte_latched_reg) |
                             (byte_out_hs & byte_strobe_fall);
            BIT_HS_IRQ_O <= (bit_in_hs & bit_strobe_fall & ~bit_latched_reg) |
                            (bit_out_hs & bit_strobe_fall);
        end
    end

    // control port: one output register, handshake lines guarded from writes
    always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            ctrl_out_reg <= `BPH_RST_CTRL_OUT;
        end else if (REG_WR_I && REG_ADDR_I == `BPH_ADDR_CTRL_PORT) begin
            if (!byte_hs_en) begin
                ctrl_out_reg[`BPH_CTRL_BYTE_HS_OUT] <= REG_WDATA_I[4 + `BPH_CTRL_BYTE_HS_OUT];
            end
            if (!bit_hs_en) begin
                ctrl_out_reg[`BPH_CTRL_BIT_HS_OUT] <= REG_WDATA_I[4 + `BPH_CTRL_BIT_HS_OUT];
            end
            ctrl_out_reg[1] <= REG_WDATA_I[5];
            ctrl_out_reg[3] <= REG_WDATA_I[7];
        end
    end

    always @* begin
        ctrl_pins_next = ctrl_out_reg;
        if (byte_in_hs) begin
            ctrl_pins_next[`BPH_CTRL_BYTE_HS_OUT] = byte_rdy_reg;
        end else if (byte_out_hs) begin
            ctrl_pins_next[`BPH_CTRL_BYTE_HS_OUT] = (byte_tx_state_reg != ST_SENT);
        end
        if (bit_in_hs) begin
            ctrl_pins_next[`BPH_CTRL_BIT_HS_OUT] = bit_rdy_reg;
        end else if (bit_out_hs) begin
            ctrl_pins_next[`BPH_CTRL_BIT_HS_OUT] = bit_dav_reg;
        end
    end

    // per-bit drive of the bit port
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
            wire spi_out;
            wire spi_in;
            wire is_out;
            wire level;
            assign spi_out = SERIAL_EN_I & (gi == `BPH_BIT_LINE_SDO);
            assign spi_in = SERIAL_EN_I & (gi == `BPH_BIT_LINE_SDI);
            assign is_out = ~bit_port_direction_reg[gi] & ~spi_in;
            assign level = spi_out ? SERIAL_DATA_OUT_I : bit_out_reg[gi];
            always @(posedge CORE_CLK_I) begin
                if (!RST_B_I) begin
                    BIT_PORT_O[gi] <= 1'b0;
                    BIT_PORT_OE_O[gi] <= 1'b0;
                end else begin
                    BIT_PORT_O[gi] <= level;
                    BIT_PORT_OE_O[gi] <= (is_out | spi_out) &
                        (control_port_mode_reg[`BPH_CM_PUSH_PULL] | ~level);
                end
            end
        end
    endgenerate

    assign bit_read = bit_in_hs ? ((bit_in_reg & bit_hs_lines) | (BIT_PORT_I & ~bit_hs_lines)) : BIT_PORT_I;

    // read mux
    always @* begin
        rdata_next = 8'h00;
        case (REG_ADDR_I)
            `BPH_ADDR_BYTE_PORT: rdata_next = byte_in_hs ? byte_in_reg : BYTE_PORT_I;
            `BPH_ADDR_BIT_PORT: rdata_next = bit_read;
            `BPH_ADDR_CTRL_PORT: rdata_next = {CTRL_PORT_O, ctrl_sync2_reg};
            `BPH_ADDR_BIT_DIR: rdata_next = bit_port_direction_reg;
            `BPH_ADDR_SHARED_MODE: rdata_next = shared_port_mode_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // pin and read-data flops
    always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            REG_RDATA_O <= 8'h00;
            BYTE_PORT_O <= `BPH_RST_BYTE;
            BYTE_PORT_OE_O <= 8'h00;
            BYTE_TX_READY_O <= 1'b0;
            SERIAL_DATA_IN_O <= 1'b0;
            CTRL_PORT_O <= `BPH_RST_CTRL_OUT;
        end else begin
            if (REG_RD_I) begin
                REG_RDATA_O <= rdata_next;
            end
            BYTE_PORT_O <= byte_is_ad ? EXT_MEM_AD_I : byte_out_reg;
            BYTE_PORT_OE_O <= {8{byte_is_ad ? EXT_MEM_AD_OE_I : byte_is_out}};
            BYTE_TX_READY_O <= fifo_in_ready;
            SERIAL_DATA_IN_O <= BIT_PORT_I[`BPH_BIT_LINE_SDI];
            CTRL_PORT_O <= ctrl_pins_next;
        end
    end
endmodule
`default_nettype wire

// ---- bph_ports_asserts.sv ----
// checker for the byte, bit and control ports
`timescale 1ns/1ps
`default_nettype none
module bph_ports_chk (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic [7:0] BYTE_PORT_OE_O,
    input wire logic [7:0] BIT_PORT_I,
    input wire logic [7:0] BIT_PORT_O,
    input wire logic [7:0] BIT_PORT_OE_O,
    input wire logic SERIAL_EN_I,
    input wire logic SERIAL_DATA_OUT_I,
    input wire logic SERIAL_DATA_IN_O,
    input wire logic [3:0] CTRL_PORT_O,
    input wire logic BYTE_HS_IRQ_O,
    input wire logic BIT_HS_IRQ_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence s_bit_wr;
        REG_WR_I && REG_ADDR_I == 8'h02 && !SERIAL_EN_I;
    endsequence
    sequence s_ctrl_wr;
        REG_WR_I && REG_ADDR_I == 8'h03;
    endsequence
    sequence s_ctrl_rd;
        REG_RD_I && REG_ADDR_I == 8'h03;
    endsequence
    chk_byte_oe_equal: assert property (BYTE_PORT_OE_O == 8'h00 || BYTE_PORT_OE_O == 8'hff)
        else $error("byte port enables differ");
    chk_bit_write_drive: assert property (s_bit_wr ##1 !SERIAL_EN_I |=>
        ((BIT_PORT_O ^ $past(REG_WDATA_I, 2)) & BIT_PORT_OE_O) == 8'h00)
        else $error("bit port drives other than written data");
    chk_ctrl_write_free: assert property (s_ctrl_wr |=> ##1
        CTRL_PORT_O[3] == $past(REG_WDATA_I[7], 2) && CTRL_PORT_O[1] == $past(REG_WDATA_I[5], 2))
        else $error("control output register not written");
    chk_ctrl_read_out: assert property (s_ctrl_rd |=> REG_RDATA_O[7:4] == $past(CTRL_PORT_O))
        else $error("control read upper nibble wrong");
    chk_serial_in_copy: assert property (SERIAL_EN_I |=> SERIAL_DATA_IN_O == $past(BIT_PORT_I[0]))
        else $error("serial input not taken from line 0");
    chk_serial_out_line: assert property (SERIAL_EN_I ##1 (SERIAL_EN_I && BIT_PORT_OE_O[7]) |->
        BIT_PORT_O[7] == $past(SERIAL_DATA_OUT_I))
        else $error("serial output not on line 7");
    chk_byte_irq_pulse: assert property (BYTE_HS_IRQ_O |=> !BYTE_HS_IRQ_O)
        else $error("byte irq longer than one cycle");
    chk_bit_irq_pulse: assert property (BIT_HS_IRQ_O |=> !BIT_HS_IRQ_O)
        else $error("bit irq longer than one cycle");
endmodule
bind bph_ports bph_ports_chk u_chk (.CORE_CLK_I, .RST_B_I, .REG_ADDR_I, .REG_WR_I, .REG_WDATA_I, .REG_RD_I,
    .REG_RDATA_O, .BYTE_PORT_OE_O, .BIT_PORT_I, .BIT_PORT_O, .BIT_PORT_OE_O, .SERIAL_EN_I,
    .SERIAL_DATA_OUT_I, .SERIAL_DATA_IN_O, .CTRL_PORT_O, .BYTE_HS_IRQ_O, .BIT_HS_IRQ_O);
`default_nettype wire

// ---- byte_ports_with_handshake_tb_top.sv ----
// self-checking testbench for the byte, bit and control ports
`timescale 1ns/1ps
`default_nettype none
module byte_ports_with_handshake_tb_top;
    logic clk, rst_b, wr, rd, ext_oe, ser_en, ser_do;
    logic [7:0] addr, wdata, ext_ad, bit_ext;
    logic [2:0] ctrl_lo;
    wire [7:0] rdata, byte_o, byte_oe, bit_o, bit_oe, peer_data;
    wire tx_rdy, ser_di, irq_b, irq_t, peer_hs;
    wire [3:0] ctrl_o;
    wire [7:0] byte_pins = byte_oe[0] ? byte_o : peer_data;
    wire [7:0] bit_pins = (bit_oe & bit_o) | (~bit_oe & bit_ext);
    int fails, tests_run, irq_b_cnt, irq_t_cnt, n;
    bph_ports dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .BYTE_PORT_I(byte_pins), .BYTE_PORT_O(byte_o),
        .BYTE_PORT_OE_O(byte_oe), .EXT_MEM_AD_I(ext_ad), .EXT_MEM_AD_OE_I(ext_oe), .BYTE_TX_READY_O(tx_rdy),
        .BIT_PORT_I(bit_pins), .BIT_PORT_O(bit_o), .BIT_PORT_OE_O(bit_oe), .SERIAL_EN_I(ser_en),
        .SERIAL_DATA_OUT_I(ser_do), .SERIAL_DATA_IN_O(ser_di), .CTRL_PORT_I({peer_hs, ctrl_lo}),
        .CTRL_PORT_O(ctrl_o), .BYTE_HS_IRQ_O(irq_b), .BIT_HS_IRQ_O(irq_t));
    bph_periph_model peer (.clk_i(clk), .dev_data_i(byte_o), .dev_hs_i(ctrl_o[0]), .peer_data_o(peer_data),
        .peer_hs_o(peer_hs));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (irq_b === 1'b1) irq_b_cnt <= irq_b_cnt + 1;
        if (irq_t === 1'b1) irq_t_cnt <= irq_t_cnt + 1;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(what, rdata, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_reset();
        logic [7:0] a[4] = '{8'hf8, 8'hf6, 8'hf7, 8'h55};
        logic [7:0] e[4] = '{8'h08, 8'hff, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) rd_chk(a[i], e[i], "mode reset");
        check("bit oe", bit_oe, 8'h00);
        check("ctrl out", {4'h0, ctrl_o}, 8'h0f);
    endtask
    task automatic t_ctrl();
        rd_chk(8'h03, 8'hfd, "ctrl read");
        wr_reg(8'h03, 8'ha0);
        rd_chk(8'h03, 8'had, "ctrl write");
        wr_reg(8'hf7, 8'h18);
        wr_reg(8'h03, 8'h00);
        rd_chk(8'h03, 8'h1d, "ctrl hs line kept");
    endtask
    task automatic t_byte_in_hs();
        peer.send(8'h96, 1'b1);
        peer.send(8'h3c, 1'b0);
        repeat (2) @(negedge clk);
        check("ready held", {7'h0, ctrl_o[0]}, 8'h00);
        check("capture irqs", 8'(irq_b_cnt), 8'h01);
        rd_chk(8'h01, 8'h96, "captured byte");
        for (n = 0; n < 20 && ctrl_o[0] !== 1'b1; n++) @(negedge clk);
        check("ready back", {7'h0, ctrl_o[0]}, 8'h01);
        wr_reg(8'hf7, 8'h00);
        peer.drive(8'h5a);
        rd_chk(8'h01, 8'h5a, "live input");
    endtask
    task automatic t_byte_out();
        wr_reg(8'hf8, 8'h00);
        wr_reg(8'h01, 8'hc3);
        settle();
        check("byte out", byte_o, 8'hc3);
        check("byte oe", byte_oe, 8'hff);
        rd_chk(8'h01, 8'hc3, "byte pins");
        wr_reg(8'hf8, 8'h10);
        settle();
        check("addr data", byte_o, 8'h77);
        wr_reg(8'hf8, 8'h00);
    endtask
    task automatic t_byte_out_hs();
        wr_reg(8'h03, 8'hf0);
        wr_reg(8'hf7, 8'h18);
        settle();
        peer.rx_en = 1'b1;
        wr_reg(8'h01, 8'ha5);
        for (n = 0; n < 40 && peer.rx_count != 1; n++) @(negedge clk);
        check("sent byte", peer.rx_last, 8'ha5);
        for (n = 0; n < 40 && irq_b_cnt != 2; n++) @(negedge clk);
        check("ready irq", 8'(irq_b_cnt), 8'h02);
        settle();
        peer.rx_en = 1'b0;
        for (int i = 0; i < 18; i++) wr_reg(8'h01, 8'h40 + 8'(i));
        @(negedge clk);
        check("fifo full", {7'h0, tx_rdy}, 8'h00);
        peer.rx_en = 1'b1;
        for (n = 0; n < 2000 && peer.rx_count != 18; n++) @(negedge clk);
        settle();
        check("sent count", 8'(peer.rx_count), 8'd18);
        check("last sent", peer.rx_last, 8'h50);
    endtask
    task automatic t_bit();
        wr_reg(8'hf6, 8'h0f);
        wr_reg(8'hf7, 8'h01);
        wr_reg(8'h02, 8'ha5);
        settle();
        check("bit oe", bit_oe, 8'hf0);
        check("bit out", bit_o & 8'hf0, 8'ha0);
        rd_chk(8'h02, 8'hac, "bit pins");
        wr_reg(8'hf7, 8'h00);
        wr_reg(8'h02, 8'h50);
        settle();
        check("open drain oe", bit_oe, 8'ha0);
        rd_chk(8'h02, 8'h1c, "open drain pins");
        wr_reg(8'hf7, 8'h01);
        ser_do <= 1'b1;
        ser_en <= 1'b1;
        bit_ext <= 8'h3d;
        settle();
        check("serial out", {7'h0, bit_o[7]}, 8'h01);
        check("serial in", {7'h0, ser_di}, 8'h01);
        @(posedge clk) ser_en <= 1'b0;
        ctrl_lo[1] <= 1'b1;
        wr_reg(8'hf6, 8'hff);
        wr_reg(8'hf7, 8'h40);
        bit_ext <= 8'h69;
        ctrl_lo[1] <= 1'b0;
        repeat (8) @(posedge clk);
        bit_ext <= 8'h00;
        ctrl_lo[1] <= 1'b1;
        rd_chk(8'h02, 8'h69, "bit captured");
        check("bit irqs", 8'(irq_t_cnt), 8'h01);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        ext_ad = 8'h77;
        ext_oe = 1'b1;
        ser_en = 1'b0;
        ser_do = 1'b0;
        bit_ext = 8'h3c;
        ctrl_lo = 3'b101;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_ctrl();
        t_byte_in_hs();
        t_byte_out();
        t_byte_out_hs();
        t_bit();
        conclude();
    end
endmodule
`default_nettype wire
